// >>> orcs_pkg.sv
// Package for the output relay condition selector.
// Assumes one 200 MHz clock; frequencies in 0.1 Hz units.
`default_nettype none
package orcs_pkg;
  localparam int FREQ_W = 12;
  localparam int SEL_W = 5;
  localparam int MASK_W = 3;
  // Frequency settings, 0.1 Hz steps
  localparam logic [FREQ_W-1:0] FREQ_SPAN_MAX = 12'h7D0;
  localparam logic [FREQ_W-1:0] BANDWIDTH_RST = 12'h064;
  localparam logic [FREQ_W-1:0] LEVEL_RST = 12'h12C;
  localparam logic [FREQ_W-1:0] MAX_FREQ_RST = 12'h258;
  // Relay source codes
  localparam logic [SEL_W-1:0] SRC_FREQ_MATCH = 5'h00;
  localparam logic [SEL_W-1:0] SRC_LEVEL_MATCH = 5'h01;
  localparam logic [SEL_W-1:0] SRC_RUN_WINDOW = 5'h02;
  localparam logic [SEL_W-1:0] SRC_THRESHOLD = 5'h03;
  localparam logic [SEL_W-1:0] SRC_THRESHOLD_INV = 5'h04;
  localparam logic [SEL_W-1:0] SRC_OVER_VOLT = 5'h08;
  localparam logic [SEL_W-1:0] SRC_LOW_VOLT = 5'h09;
  localparam logic [SEL_W-1:0] SRC_OVERHEAT = 5'h0A;
  localparam logic [SEL_W-1:0] SRC_CMD_LOSS = 5'h0B;
  localparam logic [SEL_W-1:0] SRC_RUNNING = 5'h0C;
  localparam logic [SEL_W-1:0] SRC_STOPPED = 5'h0D;
  localparam logic [SEL_W-1:0] SRC_CONST_SPEED = 5'h0E;
  localparam logic [SEL_W-1:0] SRC_RUN_WAIT = 5'h10;
  localparam logic [SEL_W-1:0] SRC_FAULT = 5'h11;
  localparam logic [SEL_W-1:0] SRC_MAX = 5'h12;
  // Fault relay mask bits
  localparam int MASK_LOW_VOLT = 0;
  localparam int MASK_OTHER_TRIP = 1;
  localparam int MASK_RESTART = 2;
  localparam logic [MASK_W-1:0] MASK_RST = 3'h0;
  // Register offsets
  localparam logic [3:0] ADDR_SELECT = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_LEVEL = 4'h2;
  localparam logic [3:0] ADDR_BANDWIDTH = 4'h3;
  localparam logic [3:0] ADDR_MAX_FREQ = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
  localparam int IRQ_W = 2;
  localparam int IRQ_RELAY_ON = 0;
  localparam int IRQ_REJECT = 1;
  typedef struct packed {
    logic over_volt_trip;
    logic low_volt_trip;
    logic other_trip;
    logic heatsink_overheat;
    logic cmd_loss;
    logic run_cmd;
    logic output_active;
    logic accelerating;
    logic decelerating;
    logic run_wait;
    logic restart_pending;
  } orcs_status_type;
endpackage
`default_nettype wire

// >>> orcs_relay_select.sv
// Output relay condition selector: picks one drive condition onto the relay.
// Assumes drive status inputs come from logic on clk; settings via a plain port.
//
// Notes on behaviour
// - Code 17 drives relay from the fault relay mask.
// - Mask bit0 low-voltage trip, bit1 other trip, bit2 restart tries set.
// - Mode 1: relay on when |command - output| <= bandwidth/2.
// - Bandwidth 0..200 Hz, default 10.0, rejected above maximum frequency.
// - Mode 2: command equals level and mode-1 condition holds.
// - Level 0..200 Hz, default 30.0, not allowed above maximum frequency.
// - Mode 3: relay on when |level - running freq| <= bandwidth/2.
// - Mode 4: accel freq >= level; decel freq > level - bandwidth/2.
// - Mode 5: same as mode 4, inverted sense.
// - Over-voltage code: relay follows over-voltage trip.
// - Low-voltage code: relay follows low-voltage trip.
// - Overheat code: relay follows heatsink overheat flag.
// - Command-loss code: relay follows frequency command loss.
// - Running code: run command present and output voltage active.
// - Stopped code: drive stopped with no run command.
// - Constant-speed code: output active, neither accelerating nor decelerating.
// - Run-wait code: relay on while waiting for run command.
// - Select accepts 0..18, defaults to 17.
`default_nettype none
module orcs_relay_select (
  input wire logic clk, // 200 MHz system clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic [orcs_pkg::FREQ_W-1:0] cmd_freq, // Commanded frequency, 0.1 Hz
  input wire logic [orcs_pkg::FREQ_W-1:0] out_freq, // Running frequency, 0.1 Hz
  input wire orcs_pkg::orcs_status_type drive_status, // Drive state flags
  input wire logic [3:0] reg_addr, // Register address
  input wire logic [15:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [15:0] reg_rdata, // Read data, cycle after strobe
  output logic relay_out, // Relay drive, high energises
  output logic irq // Level interrupt
);
  logic [orcs_pkg::SEL_W-1:0] select_reg;
  logic [orcs_pkg::MASK_W-1:0] mask_reg;
  logic [orcs_pkg::FREQ_W-1:0] level_reg;
  logic [orcs_pkg::FREQ_W-1:0] bandwidth_reg;
  logic [orcs_pkg::FREQ_W-1:0] max_freq_reg;
  logic [orcs_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [orcs_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [orcs_pkg::IRQ_W-1:0] irq_event;
  logic threshold_reg;
  logic threshold_next;
  logic relay_next;
  logic reject;
  logic [orcs_pkg::FREQ_W-1:0] half_bw;
  logic [orcs_pkg::FREQ_W-1:0] wdata_f;
  logic wdata_hi;
  logic match_cond;
  logic level_cond;
  logic window_cond;
  logic fault_cond;

  function automatic logic within_half(input logic [orcs_pkg::FREQ_W-1:0] a,
                                       input logic [orcs_pkg::FREQ_W-1:0] b,
                                       input logic [orcs_pkg::FREQ_W-1:0] hb);
    logic [orcs_pkg::FREQ_W-1:0] diff;
    diff = (a >= b) ? a - b : b - a;
    return diff <= hb;
  endfunction

  // Frequency setting is legal only within span and maximum frequency
  function automatic logic freq_ok(input logic [orcs_pkg::FREQ_W-1:0] f,
                                   input logic [orcs_pkg::FREQ_W-1:0] fmax);
    return (f <= orcs_pkg::FREQ_SPAN_MAX) && (f <= fmax);
  endfunction

  assign wdata_f = reg_wdata[orcs_pkg::FREQ_W-1:0];
  // Upper write bits would otherwise wrap a huge value into range
  assign wdata_hi = |reg_wdata[$bits(reg_wdata)-1:orcs_pkg::FREQ_W];
  assign half_bw = bandwidth_reg >> 1;
  assign match_cond = within_half(cmd_freq, out_freq, half_bw);
  assign level_cond = (cmd_freq == level_reg) && match_cond;
  assign window_cond = within_half(level_reg, out_freq, half_bw);

  // Hysteresis for modes 4 and 5; level below half bandwidth sets the decel threshold true
  always_comb begin
    threshold_next = threshold_reg;
    if (drive_status.decelerating) begin
      if (level_reg < half_bw) begin
        threshold_next = 1'b1;
      end else begin
        threshold_next = out_freq > (level_reg - half_bw);
      end
    end else begin
      threshold_next = out_freq >= level_reg;
    end
  end

  always_comb begin
    fault_cond = 1'b0;
    if (mask_reg[orcs_pkg::MASK_LOW_VOLT] && drive_status.low_volt_trip) begin
      fault_cond = 1'b1;
    end
    if (mask_reg[orcs_pkg::MASK_OTHER_TRIP] && drive_status.other_trip) begin
      fault_cond = 1'b1;
    end
    if (mask_reg[orcs_pkg::MASK_RESTART] && drive_status.restart_pending) begin
      fault_cond = 1'b1;
    end
  end

  // One source only; undefined codes hold the relay off
  always_comb begin
    case (select_reg)
      orcs_pkg::SRC_FREQ_MATCH: relay_next = match_cond;
      orcs_pkg::SRC_LEVEL_MATCH: relay_next = level_cond;
      orcs_pkg::SRC_RUN_WINDOW: relay_next = window_cond;
      orcs_pkg::SRC_THRESHOLD: relay_next = threshold_next;
      orcs_pkg::SRC_THRESHOLD_INV: relay_next = !threshold_next;
      orcs_pkg::SRC_OVER_VOLT: relay_next = drive_status.over_volt_trip;
      orcs_pkg::SRC_LOW_VOLT: relay_next = drive_status.low_volt_trip;
      orcs_pkg::SRC_OVERHEAT: relay_next = drive_status.heatsink_overheat;
      orcs_pkg::SRC_CMD_LOSS: relay_next = drive_status.cmd_loss;
      orcs_pkg::SRC_RUNNING: begin
        relay_next = drive_status.run_cmd && drive_status.output_active;
      end
      orcs_pkg::SRC_STOPPED: begin
        relay_next = !drive_status.run_cmd && !drive_status.output_active;
      end
      orcs_pkg::SRC_CONST_SPEED: begin
        relay_next = drive_status.output_active && !drive_status.accelerating &&
                     !drive_status.decelerating;
      end
      orcs_pkg::SRC_RUN_WAIT: relay_next = drive_status.run_wait;
      orcs_pkg::SRC_FAULT: relay_next = fault_cond;
      default: relay_next = 1'b0;
    endcase
  end

  // Rejected frequency writes leave the old setting in place
  always_comb begin
    reject = 1'b0;
    if (reg_wr && (reg_addr == orcs_pkg::ADDR_LEVEL)) begin
      reject = wdata_hi || !freq_ok(wdata_f, max_freq_reg);
    end else if (reg_wr && (reg_addr == orcs_pkg::ADDR_BANDWIDTH)) begin
      reject = wdata_hi || !freq_ok(wdata_f, max_freq_reg);
    end else if (reg_wr && (reg_addr == orcs_pkg::ADDR_SELECT)) begin
      reject = reg_wdata > 16'(orcs_pkg::SRC_MAX);
    end else if (reg_wr && (reg_addr == orcs_pkg::ADDR_MAX_FREQ)) begin
      reject = wdata_hi || (wdata_f > orcs_pkg::FREQ_SPAN_MAX);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      select_reg <= orcs_pkg::SRC_FAULT;
      mask_reg <= orcs_pkg::MASK_RST;
      level_reg <= orcs_pkg::LEVEL_RST;
      bandwidth_reg <= orcs_pkg::BANDWIDTH_RST;
      max_freq_reg <= orcs_pkg::MAX_FREQ_RST;
      irq_mask_reg <= '0;
    end else if (reg_wr && !reject) begin
      if (reg_addr == orcs_pkg::ADDR_SELECT) begin
        select_reg <= reg_wdata[orcs_pkg::SEL_W-1:0];
      end else if (reg_addr == orcs_pkg::ADDR_MASK) begin
        mask_reg <= reg_wdata[orcs_pkg::MASK_W-1:0];
      end else if (reg_addr == orcs_pkg::ADDR_LEVEL) begin
        level_reg <= wdata_f;
      end else if (reg_addr == orcs_pkg::ADDR_BANDWIDTH) begin
        bandwidth_reg <= wdata_f;
      end else if (reg_addr == orcs_pkg::ADDR_MAX_FREQ) begin
        max_freq_reg <= wdata_f;
      end else if (reg_addr == orcs_pkg::ADDR_IRQ_MASK) begin
        irq_mask_reg <= reg_wdata[orcs_pkg::IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      threshold_reg <= 1'b0;
      relay_out <= 1'b0;
    end else begin
      threshold_reg <= threshold_next;
      relay_out <= relay_next;
    end
  end

  assign irq_event[orcs_pkg::IRQ_RELAY_ON] = relay_next && !relay_out;
  assign irq_event[orcs_pkg::IRQ_REJECT] = reject;

  // Set beats write-one-to-clear in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_reg <= '0;
      irq <= 1'b0;
    end else begin
      if (reg_wr && (reg_addr == orcs_pkg::ADDR_IRQ_STAT)) begin
        irq_stat_reg <= (irq_stat_reg & ~reg_wdata[orcs_pkg::IRQ_W-1:0]) | irq_event;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_event;
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == orcs_pkg::ADDR_SELECT) begin
        reg_rdata <= {11'h000, select_reg};
      end else if (reg_addr == orcs_pkg::ADDR_MASK) begin
        reg_rdata <= {13'h0000, mask_reg};
      end else if (reg_addr == orcs_pkg::ADDR_LEVEL) begin
        reg_rdata <= {4'h0, level_reg};
      end else if (reg_addr == orcs_pkg::ADDR_BANDWIDTH) begin
        reg_rdata <= {4'h0, bandwidth_reg};
      end else if (reg_addr == orcs_pkg::ADDR_MAX_FREQ) begin
        reg_rdata <= {4'h0, max_freq_reg};
      end else if (reg_addr == orcs_pkg::ADDR_STATUS) begin
        reg_rdata <= {14'h0000, threshold_reg, relay_out};
      end else if (reg_addr == orcs_pkg::ADDR_IRQ_STAT) begin
        reg_rdata <= {14'h0000, irq_stat_reg};
      end else if (reg_addr == orcs_pkg::ADDR_IRQ_MASK) begin
        reg_rdata <= {14'h0000, irq_mask_reg};
      end else begin
        reg_rdata <= '0;
      end
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule
`default_nettype wire

// >>> orcs_relay_select_props.sv
// Checker for the relay selector: shadows select and mask, checks the relay.
// Assumes select writes above 18 are refused and the relay lags one cycle.
`default_nettype none
module orcs_relay_select_props (
  input wire logic clk, // System clock
  input wire logic rst_b, // Reset, active low
  input wire logic [11:0] cmd_freq, // Commanded frequency
  input wire logic [11:0] out_freq, // Running frequency
  input wire orcs_pkg::orcs_status_type drive_status, // Drive flags
  input wire logic [3:0] reg_addr, // Register address
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [15:0] reg_rdata, // Read data
  input wire logic relay_out, // Relay drive
  input wire logic irq // Interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] sel_reg;
  logic run_hit;
  logic stop_hit;
  logic steady_hit;
  assign run_hit = drive_status.run_cmd && drive_status.output_active;
  assign stop_hit = !drive_status.run_cmd && !drive_status.output_active;
  assign steady_hit = drive_status.output_active && !drive_status.accelerating &&
    !drive_status.decelerating;
  logic [2:0] mask_reg;
  logic fault_hit;
  assign fault_hit = |(mask_reg & {drive_status.restart_pending, drive_status.other_trip,
    drive_status.low_volt_trip});
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_reg <= 5'h11;
    end else if (reg_wr && reg_addr == 4'h0 && reg_wdata <= 16'h0012) begin
      sel_reg <= reg_wdata[4:0];
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_reg <= 3'h0;
    end else if (reg_wr && reg_addr == 4'h1) begin
      mask_reg <= reg_wdata[2:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence sel_read;
    reg_rd && reg_addr == 4'h0;
  endsequence
  fault_relay_a: assert property (sel_reg == 5'h11 |=> relay_out == $past(fault_hit))
    else $error("fault relay mismatch");
  over_volt_a: assert property (sel_reg == 5'h08 |=>
    relay_out == $past(drive_status.over_volt_trip))
    else $error("over-voltage relay mismatch");
  low_volt_a: assert property (sel_reg == 5'h09 |=>
    relay_out == $past(drive_status.low_volt_trip))
    else $error("low-voltage relay mismatch");
  overheat_a: assert property (sel_reg == 5'h0A |=>
    relay_out == $past(drive_status.heatsink_overheat))
    else $error("overheat relay mismatch");
  cmd_loss_a: assert property (sel_reg == 5'h0B |=>
    relay_out == $past(drive_status.cmd_loss))
    else $error("command loss relay mismatch");
  running_a: assert property (sel_reg == 5'h0C |=> relay_out == $past(run_hit))
    else $error("running relay mismatch");
  stopped_a: assert property (sel_reg == 5'h0D |=> relay_out == $past(stop_hit))
    else $error("stopped relay mismatch");
  const_speed_a: assert property (sel_reg == 5'h0E |=>
    relay_out == $past(steady_hit))
    else $error("constant speed relay mismatch");
  run_wait_a: assert property (sel_reg == 5'h10 |=>
    relay_out == $past(drive_status.run_wait))
    else $error("run wait relay mismatch");
  unused_code_a: assert property (
    sel_reg inside {5'h05, 5'h06, 5'h07, 5'h0F, 5'h12} |=> !relay_out)
    else $error("unused code drove relay");
  select_read_a: assert property (sel_read |=> reg_rdata == {11'h000, $past(sel_reg)})
    else $error("select read mismatch");
endmodule
bind orcs_relay_select orcs_relay_select_props orcs_relay_select_props_i (.clk(clk),
  .rst_b(rst_b), .cmd_freq(cmd_freq), .out_freq(out_freq), .drive_status(drive_status),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .relay_out(relay_out), .irq(irq));
`default_nettype wire

// >>> orcs_relay_load.sv
// Equipment wired to the relay contact: follows the coil one cycle late.
// Assumes relay_out high energises the coil.
`default_nettype none
module orcs_relay_load (
  input wire logic clk, // System clock
  input wire logic rst_b, // Reset, active low
  input wire logic relay_out, // Coil drive
  output logic contact_closed // Contact state seen by the load
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      contact_closed <= 1'b0;
    end else begin
      contact_closed <= relay_out;
    end
  end
endmodule
`default_nettype wire

// >>> orcs_relay_select_tb.sv
// Testbench for the relay selector: every code with random drive states.
// Assumes level and bandwidth are back at reset values for the relay sweep.
`default_nettype none
module orcs_relay_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, relay_out, irq;
  logic [11:0] cmd_freq = 12'h000, out_freq = 12'h000;
  orcs_pkg::orcs_status_type drive_status = '0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic contact;
  int error_cnt = 0, check_count = 0, seed = 32'h597293b2;
  orcs_relay_select orcs_relay_select_i (.clk(clk), .rst_b(rst_b), .cmd_freq(cmd_freq),
    .out_freq(out_freq), .drive_status(drive_status), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .relay_out(relay_out), .irq(irq));
  orcs_relay_load orcs_relay_load_i (.clk(clk), .rst_b(rst_b), .relay_out(relay_out),
    .contact_closed(contact));
  initial begin
    forever #2.5 clk = ~clk;
  end
  function automatic logic exp_relay(int s, int m, int c, int o, orcs_pkg::orcs_status_type t);
    int d1, d3;
    logic thr;
    d1 = (c > o) ? c - o : o - c;
    d3 = (o > 300) ? o - 300 : 300 - o;
    // Half bandwidth is 50, so the decel limit is 250
    thr = t.decelerating ? (o > 250) : (o >= 300);
    case (s)
      0: return d1 <= 50;
      1: return c == 300 && d1 <= 50;
      2: return d3 <= 50;
      3: return thr;
      4: return !thr;
      8: return t.over_volt_trip;
      9: return t.low_volt_trip;
      10: return t.heatsink_overheat;
      11: return t.cmd_loss;
      12: return t.run_cmd && t.output_active;
      13: return !t.run_cmd && !t.output_active;
      14: return t.output_active && !t.accelerating && !t.decelerating;
      16: return t.run_wait;
      17: return (m[0] && t.low_volt_trip) || (m[1] && t.other_trip) ||
                 (m[2] && t.restart_pending);
      default: return 1'b0;
    endcase
  endfunction
  task automatic cmp(logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Relay one cycle after the inputs, then the far-side contact one cycle later
  task automatic relay_chk(int s, int k);
    logic exp_bit;
    exp_bit = exp_relay(s, k, cmd_freq, out_freq, drive_status);
    #1 cmp({15'h0000, relay_out}, {15'h0000, exp_bit});
    @(posedge clk);
    #1 cmp({15'h0000, contact}, {15'h0000, exp_bit});
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(logic [3:0] a, logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata, e);
  endtask
  task automatic irq_chk(logic e);
    repeat (2) @(posedge clk);
    #1 cmp({15'h0000, irq}, {15'h0000, e});
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(4'h0, 16'h0011);
    rd_chk(4'h3, 16'h0064);
    rd_chk(4'h2, 16'h012C);
    wr(4'h0, 16'h0013);
    rd_chk(4'h0, 16'h0011);
    wr(4'h3, 16'h0259);
    rd_chk(4'h3, 16'h0064);
    wr(4'h2, 16'h07D1);
    rd_chk(4'h2, 16'h012C);
    rd_chk(4'h9, 16'h0000);
    irq_chk(1'b0);
    wr(4'h7, 16'h0002);
    irq_chk(1'b1);
    rd_chk(4'h6, 16'h0002);
    wr(4'h6, 16'h0002);
    irq_chk(1'b0);
    rd_chk(4'h4, 16'h0258);
    rd_chk(4'h1, 16'h0000);
    wr(4'h4, 16'h07D1);
    rd_chk(4'h4, 16'h0258);
    wr(4'h0, 16'h0020);
    rd_chk(4'h0, 16'h0011);
    wr(4'h2, 16'h1064);
    rd_chk(4'h2, 16'h012C);
    wr(4'h3, 16'h0258);
    rd_chk(4'h3, 16'h0258);
    wr(4'h2, 16'h0000);
    rd_chk(4'h2, 16'h0000);
    wr(4'h3, 16'h0064);
    wr(4'h2, 16'h012C);
    for (int s = 0; s < 19; s++) begin
      wr(4'h0, 16'(s));
      for (int k = 0; k < 8; k++) begin
        if (s == 17) wr(4'h1, 16'(k));
        for (int n = 0; n < 8; n++) begin
          @(posedge clk);
          cmd_freq <= (n == 0) ? 12'h12C : 12'h118 + 12'($random(seed) & 63);
          out_freq <= 12'h118 + 12'($random(seed) & 127);
          drive_status <= 11'($random(seed));
          @(posedge clk);
          if (s < 5) relay_chk(s, k);
          else if (s < 12) relay_chk(s, k);
          else if (s < 17) relay_chk(s, k);
          else relay_chk(s, k);
        end
      end
    end
    rd_chk(4'h6, 16'h0003);
    irq_chk(1'b1);
    rd_chk(4'h5, {14'h0000, exp_relay(3, 0, cmd_freq, out_freq, drive_status), 1'b0});
    wrap_up();
  end
  // Whole run is about 4000 cycles; this leaves a wide margin
  initial begin
    #100us;
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
